//--- core/hpss_level_timer.sv
// hpss_level_timer: tells whether a level has stood a least number of cycles
`timescale 1ns/100ps
`default_nettype none
module hpss_level_timer
	import hpss_pkg::*;
#(
	parameter int MIN_CYC = SEL_MIN_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// watched level, already synchronised
	input wire logic level,
	// high once the current level has stood MIN_CYC cycles
	output logic reached
);

	localparam int CW = $clog2(MIN_CYC + 1);
	localparam logic [CW-1:0] LIMIT = CW'(MIN_CYC);

	logic levelPrev_q; // level seen last cycle
	logic [CW-1:0] count_q; // cycles the level has stood, saturating

	initial begin
		if (MIN_CYC < 1) begin
			$error("hpss_level_timer: MIN_CYC must be at least one");
		end
	end

	// restart on every change, saturate at the limit
	always_ff @(posedge clk) begin
		if (srst) begin
			levelPrev_q <= 1'b1;
			count_q <= '0;
			reached <= 1'b0;
		end else begin
			levelPrev_q <= level;
			if (level != levelPrev_q) begin
				count_q <= '0;
				reached <= 1'b0;
			end else if (count_q != LIMIT) begin
				count_q <= count_q + CW'(1);
				reached <= (count_q + CW'(1)) == LIMIT;
			end
		end
	end

endmodule
`default_nettype wire

//--- core/hpss_pkg.sv
// hpss_pkg: constants and carrier types of the host command port spi slave
package hpss_pkg;

	// word framing
	localparam int WORD_W = 16;
	localparam int BYTE_BITS = 8;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] WORD_END_IDX = 4'h0;
	localparam logic [CNT_W-1:0] BYTE_END_IDX = 4'h8;

	// clock rates and link limits
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCK_MIN_PERIOD_NS = 40;
	localparam int SCK_MAX_FREQ_KHZ = 25000;
	localparam int I2C_MAX_FREQ_KHZ = 400;

	// least select level held for a command reset, rounded up to cycles
	localparam int SEL_MIN_LEVEL_NS = 61;
	localparam int SEL_MIN_CYC =
		(SEL_MIN_LEVEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// synchroniser depth and reset values
	localparam int SYNC_STAGES = 2;
	localparam logic [WORD_W-1:0] IDLE_REPLY_WORD = 16'h0000;
	localparam logic [WORD_W-1:0] RX_WORD_RESET = 16'h0000;

	// events reported once per frame end
	typedef struct packed {
		logic frameEnd;
		logic cmdReset;
		logic frameAbort;
	} hpss_event_s;

	// received word handed to the command logic
	typedef struct packed {
		logic valid;
		logic [WORD_W-1:0] data;
	} hpss_word_s;

	// select level tracking in the system domain
	typedef enum logic {
		SEL_HIGH,
		SEL_LOW
	} hpss_sel_e;

endpackage

//--- core/hpss_port.sv
// hpss_port: host command port, spi slave setting, link and system sides
`timescale 1ns/100ps
`default_nettype none
module hpss_port
	import hpss_pkg::*;
#(
	parameter int SEL_LEVEL_CYC = SEL_MIN_CYC
) (
	// system clock and reset
	input wire logic clk,
	input wire logic srst,
	// link clock from the host
	input wire logic hostSclk,
	// host link pins
	input wire logic hostSelectN,
	input wire logic hostSerialIn,
	output logic hostSerialOut,
	output logic hostSerialOutEn,
	// port setting strap, caught at reset release
	input wire logic i2cModeStrap,
	output logic portIsI2c,
	// received words towards the command logic
	output hpss_word_s rxWord,
	// reply words from the command logic
	input wire logic [WORD_W-1:0] txWord,
	input wire logic txLoad,
	output logic txReady,
	// frame events, one-cycle pulses
	output hpss_event_s frameEvent
);

	initial begin
		if (SEL_LEVEL_CYC < 1) begin
			$error("hpss_port: SEL_LEVEL_CYC must be at least one");
		end
		if (WORD_W != 16) begin
			$error("hpss_port: word width must be sixteen");
		end
	end

	// ---------------- link domain, clocked by the host clock and select ---

	logic frameFresh_q; // set while select is high: next rise starts a frame
	logic [CNT_W-1:0] lenCnt_q; // clocks in this frame, modulo sixteen
	logic [WORD_W-1:0] rxShift_q; // incoming bits
	logic [WORD_W-1:0] rxHold_q; // last whole word, stable for a word time
	logic rxTog_q; // flips once per whole word
	logic edgeTag_q; // flips on the first clock of each frame in the spi setting
	logic txReqMeta_q; // first stage of the reply request
	logic txReqLink_q; // synchronised reply request
	logic txAck_q; // flips when a reply word is taken
	logic [WORD_W-1:0] txShift_q; // outgoing bits
	logic i2cLink_q; // port setting in the link domain
	logic txTog_q; // flips for each reply handed to the link
	logic [WORD_W-1:0] txHold_q; // reply word, stable until acknowledged
	logic [CNT_W-1:0] bitIdx; // bit index of the coming rise
	logic [CNT_W-1:0] nextCnt; // count after the coming rise

	// a fresh frame starts its count at zero whatever was left before
	always_comb begin
		bitIdx = frameFresh_q ? WORD_END_IDX : lenCnt_q;
		nextCnt = bitIdx + CNT_W'(1);
	end

	// select rise sets the frame start flag only
	// select high forces the frame start flag, nothing else is needed
	always_ff @(posedge hostSclk or posedge hostSelectN) begin
		if (hostSelectN) begin
			frameFresh_q <= 1'b1;
		end else begin
			frameFresh_q <= 1'b0;
		end
	end

	// sample on rising edge
	// count and shift are kept past select rise so the system side can
	// judge the frame length after the host clock has stopped
	always_ff @(posedge hostSclk) begin
		if (!hostSelectN) begin
			lenCnt_q <= nextCnt;
			rxShift_q <= {rxShift_q[WORD_W-2:0], hostSerialIn};
		end
	end

	// word every sixteen clocks
	// the word is held until the next one, sixteen clocks later, which is
	// far longer than the system side needs to take it
	always_ff @(posedge hostSclk or posedge srst) begin
		if (srst) begin
			rxHold_q <= RX_WORD_RESET;
			rxTog_q <= 1'b0;
			edgeTag_q <= 1'b0;
		end else if (!hostSelectN && !i2cLink_q) begin
			if (nextCnt == WORD_END_IDX) begin
				rxHold_q <= {rxShift_q[WORD_W-2:0], hostSerialIn};
				rxTog_q <= ~rxTog_q;
			end
			if (frameFresh_q) begin
				edgeTag_q <= ~edgeTag_q;
			end
		end
	end

	// reply request crossing into the link domain
	always_ff @(posedge hostSclk or posedge srst) begin
		if (srst) begin
			txReqMeta_q <= 1'b0;
			txReqLink_q <= 1'b0;
		end else begin
			txReqMeta_q <= txTog_q;
			txReqLink_q <= txReqMeta_q;
		end
	end

	// i2c setting silences link
	// the setting is static from one cycle after reset release and a frame
	// may begin only later, so taking it at select fall is safe and works
	// before the host clock has ever run
	always_ff @(negedge hostSelectN or posedge srst) begin
		if (srst) begin
			i2cLink_q <= 1'b0;
		end else begin
			i2cLink_q <= portIsI2c;
		end
	end

	// shift out on falling edge, msb first
	// a word boundary loads the pending reply, or the idle word if none;
	// the reply register is stable because the system side waits for ack
	always_ff @(negedge hostSclk or posedge srst) begin
		if (srst) begin
			txShift_q <= IDLE_REPLY_WORD;
			txAck_q <= 1'b0;
		end else if (!hostSelectN) begin
			if (bitIdx == WORD_END_IDX) begin
				if (txReqLink_q != txAck_q) begin
					txShift_q <= txHold_q;
					txAck_q <= txReqLink_q;
				end else begin
					txShift_q <= IDLE_REPLY_WORD;
				end
			end else begin
				txShift_q <= {txShift_q[WORD_W-2:0], 1'b0};
			end
		end
	end

	// select high releases output
	// enable rises on the first clock fall inside the frame, which is the
	// later of the two falls; select rise drops it at once
	always_ff @(negedge hostSclk or posedge hostSelectN) begin
		if (hostSelectN) begin
			hostSerialOutEn <= 1'b0;
		end else begin
			hostSerialOutEn <= !i2cLink_q;
		end
	end

	// output bit follows the msb that the shift register is about to hold
	always_ff @(negedge hostSclk or posedge srst) begin
		if (srst) begin
			hostSerialOut <= 1'b0;
		end else if (!hostSelectN) begin
			if (bitIdx == WORD_END_IDX) begin
				hostSerialOut <= (txReqLink_q != txAck_q) ?
					txHold_q[WORD_W-1] : IDLE_REPLY_WORD[WORD_W-1];
			end else begin
				hostSerialOut <= txShift_q[WORD_W-2];
			end
		end
	end

	// ---------------- system domain -------------------------------------

	logic [3:0] syncIn; // select, word toggle, frame tag, reply ack
	logic [3:0] syncOut;
	logic selSync; // select level, synchronised
	logic rxTogSync; // word toggle, synchronised
	logic tagSync; // frame tag, synchronised
	logic ackSync; // reply ack, synchronised
	logic levelLong; // current select level stood long enough
	logic rxTogSeen_q; // last word toggle handled
	logic tagSeen_q; // frame tag at the last frame end
	logic highLong_q; // the high before this frame stood long enough
	logic strapDone_q; // strap caught after reset release
	hpss_sel_e selState_q; // select level as tracked here
	logic [CNT_W-1:0] frameLen; // clocks of the ended frame, modulo 16

	assign syncIn = {hostSelectN, rxTog_q, edgeTag_q, txAck_q};
	assign selSync = syncOut[3];
	assign rxTogSync = syncOut[2];
	assign tagSync = syncOut[1];
	assign ackSync = syncOut[0];
	// quiet once select is high and the host clock has stopped
	assign frameLen = lenCnt_q;

	// select, word toggle, frame tag and reply ack cross through two flip-flops
	hpss_sync #(
		.W(4),
		.RESET_VAL(4'h8)
	) u_sync (
		.clk(clk),
		.srst(srst),
		.d(syncIn),
		.q(syncOut)
	);

	// measures how long select stands at each level
	hpss_level_timer #(
		.MIN_CYC(SEL_LEVEL_CYC)
	) u_sel_timer (
		.clk(clk),
		.srst(srst),
		.level(selSync),
		.reached(levelLong)
	);

	// port setting from strap
	// caught once after release; the i2c setting silences the link pins, received words and frame tag, so frame ends report each frame as clockless
	always_ff @(posedge clk) begin
		if (srst) begin
			strapDone_q <= 1'b0;
			portIsI2c <= 1'b0;
		end else if (!strapDone_q) begin
			strapDone_q <= 1'b1;
			portIsI2c <= i2cModeStrap;
		end
	end

	// word toggle keeps across clock stop
	always_ff @(posedge clk) begin
		if (srst) begin
			rxTogSeen_q <= 1'b0;
			rxWord <= '{valid: 1'b0, data: RX_WORD_RESET};
		end else begin
			rxTogSeen_q <= rxTogSync;
			rxWord.valid <= rxTogSync != rxTogSeen_q;
			if (rxTogSync != rxTogSeen_q) begin
				rxWord.data <= rxHold_q;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			selState_q <= SEL_HIGH;
			tagSeen_q <= 1'b0;
			highLong_q <= 1'b0;
			frameEvent <= '0;
		end else begin
			frameEvent <= '0;
			unique case (selState_q)
				SEL_HIGH: begin
					// falling select starts a frame
					if (!selSync) begin
						selState_q <= SEL_LOW;
						highLong_q <= levelLong;
					end
				end
				SEL_LOW: begin
					// rising select ends the frame
					if (selSync) begin
						selState_q <= SEL_HIGH;
						tagSeen_q <= tagSync;
						frameEvent.frameEnd <= 1'b1;
						if (tagSync == tagSeen_q) begin
							// no clock at all: reset only if both levels long
							frameEvent.cmdReset <= levelLong && highLong_q;
						end else begin
							frameEvent.frameAbort <=
								(frameLen != WORD_END_IDX) &&
								(frameLen != BYTE_END_IDX);
						end
					end
				end
			endcase
		end
	end

	// reply hand-over: one reply in flight, ready when acknowledged
	always_ff @(posedge clk) begin
		if (srst) begin
			txTog_q <= 1'b0;
			txHold_q <= IDLE_REPLY_WORD;
			txReady <= 1'b0;
		end else begin
			if (txLoad && txReady) begin
				txHold_q <= txWord;
				txTog_q <= ~txTog_q;
				txReady <= 1'b0;
			end else begin
				txReady <= (txTog_q == ackSync);
			end
		end
	end

endmodule
`default_nettype wire

//--- core/hpss_sync.sv
// hpss_sync: two flip-flop level synchroniser with a reset value
`timescale 1ns/100ps
`default_nettype none
module hpss_sync
	import hpss_pkg::*;
#(
	parameter int W = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// asynchronous level in, synchronised level out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	// first stage, read only by the second stage
	logic [W-1:0] meta_q;

	initial begin
		if (W < 1) begin
			$error("hpss_sync: width must be at least one");
		end
	end

	// two stages, both cleared to the reset value
	always_ff @(posedge clk) begin
		if (srst) begin
			meta_q <= RESET_VAL;
			q <= RESET_VAL;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule
`default_nettype wire

//--- verification/hpss_host_model.sv
// hpss_host_model: behavioural host acting as spi master on the port
`timescale 1ns/100ps
`default_nettype none
module hpss_host_model (
	// link outputs
	output logic sclk,
	output logic selN,
	output logic mosi,
	// reply line from the port, high impedance when released
	input wire logic miso
);
	// half period of the 125 ns link clock
	localparam realtime HALF = 62.5;
	// idle: clock parked high and still, select high
	initial begin
		sclk = 1'b1;
		selN = 1'b1;
		mosi = 1'b0;
	end
	// one frame of n clocks; clock parked high after bit stallAt
	task automatic frame(input logic [31:0] tx, input int n,
		input int stallAt, output logic [31:0] rx);
		rx = '0;
		// select levels kept well above the least time
		#100 selN = 1'b0;
		#(n ? HALF : 200.0);
		for (int i = 0; i < n; i++) begin
			// data moves on fall, read on rise, msb first
			sclk = 1'b0;
			mosi = tx[n-1-i];
			#HALF sclk = 1'b1;
			rx = {rx[30:0], miso};
			// clock halted high for a long spell
			if (i == stallAt) #2000;
			// period 125 ns, above the 40 ns floor
			#HALF;
		end
		// select held low across every word until here
		selN = 1'b1;
		// a released line must not keep showing the last bit
		mosi = ~mosi;
		#100;
	endtask
endmodule
`default_nettype wire

//--- verification/hpss_port_monitor.sv
// hpss_port_monitor: timing checks on the host command port pins
`timescale 1ns/100ps
`default_nettype none
module hpss_port_monitor
	import hpss_pkg::*;
#(
	parameter int SEL_LEVEL_CYC = SEL_MIN_CYC
) (
	// clocks and reset
	input wire logic clk,
	input wire logic srst,
	input wire logic hostSclk,
	// link pins
	input wire logic hostSelectN,
	input wire logic hostSerialIn,
	input wire logic hostSerialOut,
	input wire logic hostSerialOutEn,
	// strap and command side
	input wire logic i2cModeStrap,
	input wire logic portIsI2c,
	input wire hpss_word_s rxWord,
	input wire logic [WORD_W-1:0] txWord,
	input wire logic txLoad,
	input wire logic txReady,
	input wire hpss_event_s frameEvent
);
	// everything is sampled on the system clock, quiet during reset
	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	chk_oe_release: assert property (
		hostSelectN |-> !hostSerialOutEn) else $error("out enable, select high");
	chk_shift_fall: assert property (
		hostSerialOutEn && $past(hostSerialOutEn) && $changed(hostSerialOut)
		|-> !hostSclk) else $error("serial out moved off the falling edge");
	chk_end_after_rise: assert property (
		$rose(hostSelectN) && !portIsI2c |-> ##[2:4] frameEvent.frameEnd)
		else $error("no frame end after select rise");
	chk_abort_at_end: assert property (
		frameEvent.frameAbort |-> frameEvent.frameEnd) else $error("lone abort");
	chk_reset_at_end: assert property (
		frameEvent.cmdReset |-> frameEvent.frameEnd) else $error("lone reset");
	chk_word_pulse: assert property (
		rxWord.valid |=> !rxWord.valid) else $error("word valid too long");
	chk_word_hold: assert property (
		!rxWord.valid |-> $stable(rxWord.data)) else $error("word data moved");
	chk_i2c_silent: assert property (
		portIsI2c |-> !rxWord.valid && !hostSerialOutEn)
		else $error("spi slave active in i2c setting");
	chk_reply_taken: assert property (
		txLoad && txReady |=> !txReady) else $error("reply slot stayed free");
endmodule

bind hpss_port hpss_port_monitor #(.SEL_LEVEL_CYC(SEL_LEVEL_CYC)) u_mon (
	.clk, .srst, .hostSclk, .hostSelectN, .hostSerialIn, .hostSerialOut,
	.hostSerialOutEn, .i2cModeStrap, .portIsI2c, .rxWord, .txWord, .txLoad,
	.txReady, .frameEvent
);
`default_nettype wire

//--- verification/tb_top.sv
// tb_top: self-checking bench for the host command port spi slave
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import hpss_pkg::*;
	// system side inputs, given values at time zero
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic strap = 1'b0;
	logic [WORD_W-1:0] txWord = '0;
	logic txLoad = 1'b0;
	logic txReady, isI2c, sOut, sOutEn, sclk, selN, mosi;
	hpss_word_s rxWord;
	hpss_event_s ev;
	// reply wire: driven only while the port enables it
	wire logic miso = sOutEn ? sOut : 1'bz;
	int numErrors = 0;
	int samplesChecked = 0;
	int nAbort, nReset;
	logic [15:0] gotQ[$];

	hpss_port u_dut (
		.clk, .srst, .hostSclk(sclk), .hostSelectN(selN), .hostSerialIn(mosi),
		.hostSerialOut(sOut), .hostSerialOutEn(sOutEn), .i2cModeStrap(strap),
		.portIsI2c(isI2c), .rxWord, .txWord, .txLoad, .txReady, .frameEvent(ev)
	);
	hpss_host_model u_host (.sclk, .selN, .mosi, .miso);

	// 100 MHz system clock
	initial begin
		forever #5 clk = ~clk;
	end
	// collect words and frame events from the command side
	always @(posedge clk) begin
		if (rxWord.valid === 1'b1) gotQ.push_back(rxWord.data);
		if (ev.frameAbort === 1'b1) nAbort++;
		if (ev.cmdReset === 1'b1) nReset++;
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			numErrors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic clr();
		gotQ.delete();
		nAbort = 0;
		nReset = 0;
	endtask
	// reset for 3 cycles with the strap set, then flush synchronisers
	task automatic doReset(input logic s);
		@(negedge clk);
		srst = 1'b1;
		strap = s;
		repeat (3) @(negedge clk);
		srst = 1'b0;
		repeat (4) @(negedge clk);
		check("strap", isI2c, s);
		check("idle enable", sOutEn, 1'b0);
	endtask
	// two words in one frame, with a reply loaded beforehand
	task automatic tWords();
		logic [31:0] rx;
		check("slot free", txReady, 1'b1);
		@(negedge clk);
		txWord = 16'hA5C3;
		txLoad = 1'b1;
		@(negedge clk);
		txLoad = 1'b0;
		clr();
		u_host.frame(32'h1234BEEF, 32, -1, rx);
		repeat (8) @(negedge clk);
		check("words", gotQ.size(), 2);
		check("word one", gotQ[0], 16'h1234);
		check("word two", gotQ[1], 16'hBEEF);
		// the request crosses on host clock rises, so it lands at the
		// second word boundary; the first word carries the idle word
		check("reply", rx, 32'h0000A5C3);
		check("abort", nAbort, 0);
		check("released", sOutEn, 1'b0);
	endtask
	// word with the clock parked high mid-word
	task automatic tStall();
		logic [31:0] rx;
		clr();
		u_host.frame(32'h0F0F, 16, 7, rx);
		repeat (8) @(negedge clk);
		check("stalled word", gotQ[0], 16'h0F0F);
	endtask
	// odd lengths: 12 clocks is dropped, 8 clocks is legal
	task automatic tLengths();
		logic [31:0] rx;
		clr();
		u_host.frame(32'h0ABC, 12, -1, rx);
		repeat (8) @(negedge clk);
		check("partial", gotQ.size(), 0);
		check("abort 12", nAbort, 1);
		clr();
		u_host.frame(32'h5A, 8, -1, rx);
		repeat (8) @(negedge clk);
		check("abort 8", nAbort, 0);
		clr();
		u_host.frame(32'h0, 0, -1, rx);
		repeat (8) @(negedge clk);
		check("cmd reset", nReset, 1);
	endtask
	// i2c setting passes no received words to the command side
	task automatic tI2c();
		logic [31:0] rx;
		doReset(1'b1);
		clr();
		u_host.frame(32'h1111, 16, -1, rx);
		repeat (8) @(negedge clk);
		check("i2c words", gotQ.size(), 0);
		doReset(1'b0);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", samplesChecked, numErrors);
		if (numErrors == 0 && samplesChecked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// main sequence
	initial begin
		doReset(1'b0);
		tWords();
		tStall();
		tLengths();
		tI2c();
		tWords();
		tally_and_finish();
	end
	// hang guard, well past the expected run of some 19 us
	initial begin
		#200000;
		numErrors++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
